// file: inc/tx_path_pkg.sv
package tx_path_pkg;

    // APB address width and register indexes (byte address is index times four)
    localparam int          APB_AW         = 8;
    localparam logic [7:0]  CTRL_INDEX     = 8'h00;
    localparam logic [7:0]  GAIN_INDEX     = 8'h01;
    localparam logic [7:0]  STATUS_INDEX   = 8'h02;
    localparam logic [7:0]  FILTER_INDEX   = 8'h07;
    localparam logic [7:0]  CTRL_ADDR      = CTRL_INDEX << 2;
    localparam logic [7:0]  GAIN_ADDR      = GAIN_INDEX << 2;
    localparam logic [7:0]  STATUS_ADDR    = STATUS_INDEX << 2;
    localparam logic [7:0]  FILTER_ADDR    = FILTER_INDEX << 2;

    // Field positions and reset values
    localparam int          FILTER_MODE_LSB = 4;
    localparam logic [9:0]  CTRL_RESET      = 10'h020;
    localparam logic [3:0]  FILTER_RESET    = 4'h0;
    localparam logic [11:0] GAIN_RESET      = 12'h000;

    // Filter mode codes
    localparam logic [3:0]  MODE_LPF_4X   = 4'h0;
    localparam logic [3:0]  MODE_LPF_2X   = 4'h1;
    localparam logic [3:0]  MODE_ADJ_4X   = 4'h4;
    localparam logic [3:0]  MODE_ADJ_2X   = 4'h5;
    localparam logic [3:0]  MODE_LOWER_4X = 4'h8;
    localparam logic [3:0]  MODE_UPPER_4X = 4'hC;

    // Data widths
    localparam int          WORD_W = 12;
    localparam int          NIB_W  = 6;

    // Timing: reference period in mclk cycles, latencies in DAC cycles
    localparam logic [5:0]  REF_PERIOD_CYCLES = 6'h20;
    localparam int          LAT_4X     = 86;
    localparam int          LAT_2X     = 30;
    localparam int          LINE_DEPTH = LAT_4X;
    localparam logic [6:0]  TAP_BASE_4X = 7'(LAT_4X - 4);
    localparam logic [6:0]  TAP_BASE_2X = 7'(LAT_2X - 2);

    // Control fields, msb first, matching the control register layout
    typedef struct packed {
        logic [1:0] l_sel;      // DAC multiplier select: 1, 2, 4, 8
        logic       bypass;     // Pass-through, no interpolation
        logic       gain_route; // Gain pin may steer words to gain adjust
        logic       mux_en;     // Two nibbles per word
        logic       five_bit;   // Five-bit nibbles
        logic       swap;       // Second nibble is the upper half
        logic       clk_off;    // Port clock held low
        logic       clk_inv;    // Port clock inverted at the pin
        logic       cap_fall;   // Capture on falling pin edge
    } ctrl_t;

    // Nibble pairing states
    typedef enum logic [1:0] {
        ASM_FIRST  = 2'b01,
        ASM_SECOND = 2'b10
    } asm_state_t;

    // Filter spectral variants
    typedef enum logic [3:0] {
        KIND_LPF   = 4'b0001,
        KIND_ADJ   = 4'b0010,
        KIND_LOWER = 4'b0100,
        KIND_UPPER = 4'b1000
    } filter_kind_t;

endpackage : tx_path_pkg

// file: design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Asynchronous pins and their synchronised copy
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;   // Only read by the second stage

    // Two-flop synchroniser
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : pin_sync

// file: design/rate_divider.sv
`timescale 1ns/1ps
module rate_divider (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Period in mclk cycles, at least one
    input  wire logic [7:0] period,
    // One-cycle pulse per period
    output logic            tick
);

    logic [7:0] count;       // Cycles since last tick
    logic [7:0] next_count;
    logic       next_tick;

    // Wrap when period is reached; a shrinking period wraps at once
    always_comb begin
        next_count = count + 8'h01;
        next_tick  = 1'b0;
        if (count >= period - 8'h01) begin
            next_count = 8'h00;
            next_tick  = 1'b1;
        end
    end

    // Counter registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule : rate_divider

// file: design/tx_interpolating_path.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tx_interpolating_path import tx_path_pkg::*; (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Host transmit port pins
    input  wire logic [NIB_W-1:0]  transmit_nibble,
    input  wire logic              transmit_word_marker,
    input  wire logic              gain_select,
    output logic                   transmit_port_clock,
    // DAC sample stream
    output logic [WORD_W-1:0]      dac_sample,
    output logic                   dac_strobe,
    // Receive path gain adjust value
    output logic [WORD_W-1:0]      gain_adjust
);

    // Configuration registers
    ctrl_t             ctrl;              // Port and clock options
    ctrl_t             next_ctrl;
    logic [3:0]        filter_mode;       // Filter mode field
    logic [3:0]        next_filter_mode;
    logic [WORD_W-1:0] next_gain_adjust;

    // APB next values
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              addr_hit;          // Address is mapped
    logic [31:0]       read_word;         // Word read at paddr
    logic              bus_write;         // Write completes this edge

    // Synchronised pins
    logic [7:0]        pins_sync;
    logic [NIB_W-1:0]  nib;
    logic              marker;
    logic              gain_level;

    // Clocking
    logic [5:0]        dac_period;        // mclk cycles per DAC cycle
    logic [1:0]        k_log;             // log2 of interpolation factor
    logic [7:0]        half_period;       // mclk cycles per port half-cycle
    logic              dac_tick;          // One DAC sample clock cycle
    logic              half_tick;         // Port clock half-cycle boundary
    logic              port_level;        // Port clock before inversion
    logic              next_port_level;
    logic              next_pin;
    logic              cap_event;
    logic [1:0]        cap_pipe;          // Aligns capture with pin synchroniser
    logic [1:0]        next_cap_pipe;
    logic              capture;

    // Word assembly
    asm_state_t        asm_state;
    asm_state_t        next_asm_state;
    logic [NIB_W-1:0]  first_nib;         // Held first half-word
    logic [NIB_W-1:0]  next_first_nib;
    logic [WORD_W-1:0] word;              // Assembled word
    logic [WORD_W-1:0] next_word;
    logic              word_valid;        // One-cycle pulse per word
    logic              next_word_valid;
    logic [NIB_W-1:0]  hi_nib;
    logic [NIB_W-1:0]  lo_nib;

    // Filter input hand-over
    logic [WORD_W-1:0] pending;           // Word waiting for a DAC tick
    logic [WORD_W-1:0] next_pending;
    logic              pending_valid;
    logic              next_pending_valid;
    logic              to_filter;

    // Filter datapath, never reset apart from phase
    logic [WORD_W-1:0] zoh;               // Held input sample
    logic [WORD_W-1:0] next_zoh;
    logic [WORD_W-1:0] line [0:LINE_DEPTH-1];
    filter_kind_t      kind;
    logic [6:0]        tap_base;
    logic signed [13:0] acc;
    logic signed [13:0] avg;
    logic [WORD_W-1:0] filt;
    logic [1:0]        phase;             // fs/4 modulation phase
    logic [1:0]        next_phase;
    logic [WORD_W-1:0] next_dac_sample;

    // Two's complement negate, clamping the most negative code
    function automatic logic [WORD_W-1:0] neg_sat(input logic [WORD_W-1:0] v);
        logic [WORD_W-1:0] r;
        r = (~v) + 12'h001;
        if (v == 12'h800) begin
            r = 12'h7FF;
        end
        return r;
    endfunction : neg_sat

    // Pins cross into mclk through two flops
    pin_sync #(.W(8)) u_pin_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({gain_select, transmit_word_marker, transmit_nibble}),
        .sync_out (pins_sync)
    );

    assign nib        = pins_sync[5:0];
    assign marker     = pins_sync[6];
    assign gain_level = pins_sync[7];

    always_comb begin
        kind  = KIND_LPF;
        k_log = 2'd2;
        case (filter_mode)
            MODE_LPF_4X:   begin kind = KIND_LPF;   k_log = 2'd2; end
            MODE_LPF_2X:   begin kind = KIND_LPF;   k_log = 2'd1; end
            MODE_ADJ_4X:   begin kind = KIND_ADJ;   k_log = 2'd2; end
            MODE_ADJ_2X:   begin kind = KIND_ADJ;   k_log = 2'd1; end
            MODE_LOWER_4X: begin kind = KIND_LOWER; k_log = 2'd2; end
            MODE_UPPER_4X: begin kind = KIND_UPPER; k_log = 2'd2; end
            // Unlisted codes fall back to 4x low-pass
            default:       begin kind = KIND_LPF;   k_log = 2'd2; end
        endcase
        if (ctrl.bypass) begin
            k_log = 2'd0;
        end
    end

    // DAC period is reference period over L
    assign dac_period = REF_PERIOD_CYCLES >> ctrl.l_sel;

    always_comb begin
        half_period = {2'b00, dac_period} << k_log;
        if (ctrl.mux_en) begin
            // Multiplexed: two half-words per input word
            half_period = half_period >> 2;
        end else begin
            half_period = half_period >> 1;
        end
    end

    // DAC sample clock
    rate_divider u_dac_div (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .period ({2'b00, dac_period}),
        .tick   (dac_tick)
    );

    // Port clock half-cycles
    rate_divider u_port_div (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .period (half_period),
        .tick   (half_tick)
    );

    // Port clock and capture strobe
    always_comb begin
        next_port_level = half_tick ? ~port_level : port_level;
        next_pin = ctrl.clk_off ? 1'b0 : (next_port_level ^ ctrl.clk_inv);
        // Rising pin edge unless falling is chosen
        if (ctrl.cap_fall) begin
            cap_event = half_tick & ~ctrl.clk_off & ~next_pin & transmit_port_clock;
        end else begin
            cap_event = half_tick & ~ctrl.clk_off & next_pin & ~transmit_port_clock;
        end
        // Delay by the synchroniser depth so data and strobe match
        next_cap_pipe = {cap_pipe[0], cap_event};
    end

    assign capture = cap_pipe[1];

    // Port clock registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_level          <= 1'b0;
            transmit_port_clock <= 1'b0;
            cap_pipe            <= 2'b00;
        end else begin
            port_level          <= next_port_level;
            transmit_port_clock <= next_pin;
            cap_pipe            <= next_cap_pipe;
        end
    end

    // Nibble order within a word
    always_comb begin
        // Swap puts the marked nibble low
        hi_nib = ctrl.swap ? nib : first_nib;
        lo_nib = ctrl.swap ? first_nib : nib;
    end

    // Word assembly
    always_comb begin
        next_asm_state  = asm_state;
        next_first_nib  = first_nib;
        next_word       = word;
        next_word_valid = 1'b0;
        if (!ctrl.mux_en) begin
            next_asm_state = ASM_FIRST;
            if (capture) begin
                next_word       = ctrl.five_bit ? {nib[4:0], 7'h00} : {nib, 6'h00};
                next_word_valid = 1'b1;
            end
        end else if (capture) begin
            case (asm_state)
                ASM_FIRST: begin
                    if (marker) begin
                        next_first_nib = nib;
                        next_asm_state = ASM_SECOND;
                    end
                end
                ASM_SECOND: begin
                    if (marker) begin
                        // A new marker restarts the pair
                        next_first_nib = nib;
                    end else begin
                        if (ctrl.five_bit) begin
                            next_word = {hi_nib[4:0], lo_nib[4:0], 2'b00};
                        end else begin
                            next_word = {hi_nib, lo_nib};
                        end
                        next_word_valid = 1'b1;
                        next_asm_state  = ASM_FIRST;
                    end
                end
                default: begin
                    next_asm_state = ASM_FIRST;
                end
            endcase
        end
    end

    // Assembly registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            asm_state  <= ASM_FIRST;
            first_nib  <= '0;
            word       <= '0;
            word_valid <= 1'b0;
        end else begin
            asm_state  <= next_asm_state;
            first_nib  <= next_first_nib;
            word       <= next_word;
            word_valid <= next_word_valid;
        end
    end

    // Route each finished word
    always_comb begin
        // Gain pin steers words to gain adjust
        to_filter          = word_valid & ~(ctrl.gain_route & gain_level);
        // Only whole words reach the filter
        next_pending       = to_filter ? word : pending;
        // A word arriving on a tick survives the clear
        next_pending_valid = to_filter | (pending_valid & ~dac_tick);
        next_zoh           = (dac_tick && pending_valid) ? pending : zoh;
    end

    // Hand-over registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending       <= '0;
            pending_valid <= 1'b0;
        end else begin
            pending       <= next_pending;
            pending_valid <= next_pending_valid;
        end
    end

    // Delay line has no reset, contents persist
    always_ff @(posedge mclk) begin
        zoh <= next_zoh;
        if (dac_tick) begin
            line[0] <= next_zoh;
            for (int i = 1; i < LINE_DEPTH; i++) begin
                line[i] <= line[i-1];
            end
        end
    end

    // Average K held samples after a delay
    always_comb begin
        // Tap base places peak at mode latency
        tap_base = (k_log == 2'd1) ? TAP_BASE_2X : TAP_BASE_4X;
        acc      = '0;
        for (int i = 0; i < 4; i++) begin
            if (i < (1 << k_log)) begin
                acc = acc + {{2{line[7'(tap_base + 7'(i))][11]}},
                             line[7'(tap_base + 7'(i))]};
            end
        end
        avg  = acc >>> k_log;
        filt = avg[11:0];
        // Short kernel settles inside flush limits
        case (kind)
            KIND_LPF:   next_dac_sample = filt;
            KIND_ADJ:   next_dac_sample = phase[0] ? neg_sat(filt) : filt;
            KIND_LOWER: next_dac_sample = phase[0] ? 12'h000 :
                                          (phase[1] ? neg_sat(filt) : filt);
            KIND_UPPER: next_dac_sample = !phase[0] ? 12'h000 :
                                          (phase[1] ? neg_sat(filt) : filt);
            default:    next_dac_sample = filt;
        endcase
        if (ctrl.bypass) begin
            next_dac_sample = zoh;
        end
        if (!dac_tick) begin
            next_dac_sample = dac_sample;
        end
        next_phase = dac_tick ? phase + 2'd1 : phase;
    end

    // DAC output registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dac_sample <= '0;
            dac_strobe <= 1'b0;
            phase      <= 2'd0;
        end else begin
            dac_sample <= next_dac_sample;
            dac_strobe <= dac_tick;
            phase      <= next_phase;
        end
    end

    // APB decode and read mux
    always_comb begin
        addr_hit  = 1'b1;
        read_word = 32'h0000_0000;
        case (paddr)
            CTRL_ADDR:   read_word = {22'h000000, ctrl};
            GAIN_ADDR:   read_word = {20'h00000, gain_adjust};
            STATUS_ADDR: read_word = {17'h00000, pending_valid, asm_state, 12'(word)};
            FILTER_ADDR: read_word = {24'h000000, filter_mode, 4'h0};
            default:     addr_hit  = 1'b0;
        endcase
    end

    // One wait state: answer on the second access cycle
    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & ~addr_hit;
        next_prdata  = prdata;
        if (next_pready && !pwrite) begin
            next_prdata = addr_hit ? read_word : 32'h0000_0000;
        end
        bus_write        = psel & penable & pready & pwrite;
        next_ctrl        = ctrl;
        next_filter_mode = filter_mode;
        next_gain_adjust = gain_adjust;
        if (bus_write && paddr == CTRL_ADDR) begin
            next_ctrl = ctrl_t'(pwdata[9:0]);
        end
        if (bus_write && paddr == FILTER_ADDR) begin
            next_filter_mode = pwdata[FILTER_MODE_LSB +: 4];
        end
        if (bus_write && paddr == GAIN_ADDR) begin
            next_gain_adjust = pwdata[11:0];
        end
        // Port word wins over a bus write
        if (word_valid && ctrl.gain_route && gain_level) begin
            next_gain_adjust = word;
        end
    end

    // Register file and bus outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl        <= ctrl_t'(CTRL_RESET);
            filter_mode <= FILTER_RESET;
            gain_adjust <= GAIN_RESET;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            filter_mode <= next_filter_mode;
            gain_adjust <= next_gain_adjust;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
        end
    end

endmodule : tx_interpolating_path

// file: bench/tx_interpolating_path_assertions.sv
`timescale 1ns/1ps
module tx_interpolating_path_assertions import tx_path_pkg::*; (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst_n,
    // APB side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // DAC stream
    input wire logic [WORD_W-1:0] dac_sample,
    input wire logic              dac_strobe
);
    // One clock domain
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_ready_time; $rose(penable) && psel |=> pready; endproperty
    a_ready_time: assert property (p_ready_time)
        else $error("late pready");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held");
    property p_ready_in; pready |-> psel && penable; endproperty
    a_ready_in: assert property (p_ready_in)
        else $error("pready outside access");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read data");
    property p_rdata_hold; $changed(prdata) |-> pready && !pwrite; endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("prdata moved");
    // Fastest tick is every fourth cycle
    property p_strobe_gap; dac_strobe |=> !dac_strobe [*3]; endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("DAC ticks too close");
    property p_sample_on_strobe; $changed(dac_sample) |-> dac_strobe; endproperty
    a_sample_on_strobe: assert property (p_sample_on_strobe)
        else $error("sample moved off strobe");
endmodule : tx_interpolating_path_assertions

bind tx_interpolating_path tx_interpolating_path_assertions u_tx_interpolating_path_assertions (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac_sample(dac_sample),
    .dac_strobe(dac_strobe));

// file: bench/tx_host_model.sv
`timescale 1ns/1ps
module tx_host_model import tx_path_pkg::*; (
    // Port clock and the level at which the host may change data
    input  wire logic              port_clk,
    input  wire logic              fall,
    // Word to send next
    input  wire logic [WORD_W-1:0] word,
    // Host pins
    output logic      [NIB_W-1:0]  nibble,
    output logic                   marker
);
    logic [NIB_W-1:0] low_half = '0;   // Second half, held from word start
    logic             second   = 1'b0; // Second half still owed
    // Change on the edge away from capture so setup and hold are wide
    // marked first half
    always @(port_clk) begin
        if (port_clk === fall) begin
            marker   <= !second;
            nibble   <= second ? low_half : word[WORD_W-1:NIB_W];
            low_half <= word[NIB_W-1:0];
            second   <= !second;
        end
    end
endmodule : tx_host_model

// file: bench/tx_interpolating_path_tb.sv
`timescale 1ns/1ps
module tx_interpolating_path_tb import tx_path_pkg::*; ;
    // Bus, pins and bench state
    logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              gain_select, port_clk, marker, dac_strobe, fall;
    logic [NIB_W-1:0]  nibble;
    logic [WORD_W-1:0] dac_sample, gain_adjust, word;
    int                num_errors = 0;
    int                num_checks = 0;

    tx_interpolating_path u_tx_interpolating_path (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .transmit_nibble(nibble),
        .transmit_word_marker(marker), .gain_select(gain_select),
        .transmit_port_clock(port_clk), .dac_sample(dac_sample), .dac_strobe(dac_strobe),
        .gain_adjust(gain_adjust));
    tx_host_model u_tx_host_model (.port_clk(port_clk), .fall(fall), .word(word),
        .nibble(nibble), .marker(marker));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // Timeout ends the run
    task automatic hang;
        num_errors++;
        final_report();
    endtask : hang

    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer after an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic ticks(input int n);
        int c = 0;
        while (n > 0) begin
            @(posedge mclk);
            if (dac_strobe === 1'b1) n--;
            if (++c > 50000) hang();
        end
    endtask : ticks

    task automatic mk_rise;
        int c = 0;
        while (marker !== 1'b0 && ++c < 200) @(posedge mclk);
        while (marker !== 1'b1 && ++c < 200) @(posedge mclk);
        if (c >= 200) hang();
    endtask : mk_rise

    task automatic t_regs;
        apb(0, CTRL_ADDR, 0);
        chk("ctrl reset", rd, {22'h0, CTRL_RESET});
        apb(1, GAIN_ADDR, 32'h5A5);
        apb(0, GAIN_ADDR, 0);
        chk("gain", rd, 32'h5A5);
        apb(0, 8'h40, 0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        $display("test regs done");
    endtask : t_regs

    // Port edges and DAC ticks per clock setting
    task automatic t_clk;
        logic [9:0] c[6] = '{10'h0A0, 10'h1A0, 10'h2A0, 10'h3A0, 10'h080, 10'h024};
        int         e[6] = '{20, 40, 80, 160, 10, 0};
        int         k, s;
        logic       p;
        foreach (c[i]) begin
            apb(1, CTRL_ADDR, {22'h0, c[i]});
            repeat (40) @(posedge mclk);
            k = 0;
            s = 0;
            p = port_clk;
            repeat (160) begin
                @(posedge mclk);
                k += (port_clk !== p);
                s += (dac_strobe === 1'b1);
                p = port_clk;
            end
            chk("port edges", k, e[i]);
            chk("dac ticks", s, 5 << c[i][9:8]);
        end
        $display("test clocks done");
    endtask : t_clk

    // Pass-through word pairing in each port mode
    task automatic t_pairs;
        logic [9:0]  c[7] = '{10'h0A0, 10'h0A8, 10'h0B0, 10'h080, 10'h0A2, 10'h0A1, 10'h0E0};
        logic [11:0] w[7] = '{12'h5A3, 12'h5A3, 12'h5A3, 12'hAEB, 12'h3C5, 12'h2F1, 12'h123};
        logic [11:0] e[7] = '{12'h5A3, 12'h8D6, 12'hB0C, 12'hAC0, 12'h3C5, 12'h2F1, 12'h123};
        int          k;
        foreach (c[i]) begin
            apb(1, CTRL_ADDR, {22'h0, c[i]});
            fall <= c[i][0];
            word <= w[i];
            k = 0;
            while ((i == 6 ? gain_adjust : dac_sample) !== e[i] && ++k < 400) @(posedge mclk);
            chk("word", i == 6 ? gain_adjust : dac_sample, e[i]);
        end
        gain_select <= 1'b0;
        ticks(12);
        chk("gain low", dac_sample, 12'h123);
        $display("test pairs done");
    endtask : t_pairs

    // Impulse peak and settling per filter mode
    task automatic t_modes;
        logic [3:0]  m[6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'hC};
        int          lat, lim, pk, last;
        logic [11:0] a, big;
        apb(1, CTRL_ADDR, 32'h220);
        fall <= 1'b0;
        foreach (m[i]) begin
            lat = m[i][0] ? 30 : 86;
            lim = m[i][3] ? 142 : (m[i][0] ? 48 : 128);
            apb(1, FILTER_ADDR, {24'h0, m[i], 4'h0});
            apb(0, FILTER_ADDR, 0);
            chk("mode", rd, {24'h0, m[i], 4'h0});
            word <= 12'h0;
            ticks(160);
            word <= 12'hC00 ^ 12'h800;
            mk_rise();
            word <= 12'h0;
            {big, pk, last} = '0;
            for (int t = 1; t <= 200; t++) begin
                ticks(1);
                a = dac_sample[11] ? -dac_sample : dac_sample;
                if (a > big) {big, pk} = {a, t};
                if (dac_sample !== 12'h0) last = t;
            end
            chk("peak", pk >= lat && pk <= lat + 6, 1);
            chk("settle", last > 0 && last <= lim + 6, 1);
        end
        $display("test modes done");
    endtask : t_modes

    // Mid-run reset keeps the impulse
    task automatic t_keep;
        logic seen = 1'b0;
        word <= 12'h400;
        mk_rise();
        word <= 12'h0;
        ticks(20);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int t = 0; t < 200; t++) begin
            ticks(1);
            seen |= (dac_sample != 12'h0);
        end
        chk("kept", seen, 1);
        $display("test reset keep done");
    endtask : t_keep

    initial begin
        {rst_n, psel, penable, pwrite, fall, paddr, pwdata, word} = '0;
        gain_select = 1'b1;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_clk();
        t_pairs();
        t_modes();
        t_keep();
        final_report();
    end
endmodule : tx_interpolating_path_tb
